// *** design/pbo_pkg.sv ***
package pbo_pkg;

  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned PHYS_W  = 36;
  localparam int unsigned LAM_W   = 24;
  localparam int unsigned HIGH_W  = 4;

  localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_ADDR_LO  = 12'h300;
  localparam logic [ADDR_W-1:0] OFF_DATA     = 12'h304;
  localparam logic [ADDR_W-1:0] OFF_DMASK    = 12'h308;
  localparam logic [ADDR_W-1:0] OFF_CTL      = 12'h30C;
  localparam logic [ADDR_W-1:0] OFF_ADDR_HI  = 12'h310;
  localparam logic [ADDR_W-1:0] OFF_HMASK    = 12'h314;

  // control register fields, upper overlay mask and status bit positions
  localparam int unsigned CTL_LAM_LSB  = 8;
  localparam int unsigned CTL_SC_BIT   = 7;
  localparam int unsigned CTL_SU_BIT   = 6;
  localparam int unsigned CTL_OVL_BIT  = 3;
  localparam int unsigned CTL_BE_BIT   = 0;
  localparam int unsigned UOAM_LSB     = 24;
  localparam int unsigned STS_BS_BIT   = 0;

  // uncached load/fetch setting: 11 compares, 00 does not
  localparam logic [1:0] LF_COMPARE_ON  = 2'h3;
  localparam logic [1:0] LF_SETTING     = LF_COMPARE_ON;
  localparam logic [1:0] CTL_RSVD_VAL   = 2'h0;

  // status constants: overlay present, one break channel
  localparam logic [DATA_W-1:0] STS_CONST = 32'h4100_0000;

  localparam logic [DATA_W-1:0] ZERO_W    = 32'h0000_0000;
  localparam logic [LAM_W-1:0]  ZERO_LAM  = 24'h00_0000;
  localparam logic [HIGH_W-1:0] ZERO_HIGH = 4'h0;
  localparam logic [7:0]        ZERO_UP   = 8'h00;

endpackage : pbo_pkg

// *** design/pbo_bus_break.sv ***
`timescale 1ns/1ps
module pbo_bus_break (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  input  wire logic [pbo_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pbo_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [pbo_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       bus_req_valid,
  input  wire logic [pbo_pkg::PHYS_W-1:0] bus_addr,
  input  wire logic [pbo_pkg::DATA_W-1:0] bus_data,
  input  wire logic                       bus_is_store,
  input  wire logic                       bus_cached,
  input  wire logic                       debug_mode_active,
  input  wire logic                       debug_exc_ack,
  input  wire logic                       probe_proc_reset,
  output logic                            overlay_redirect,
  output logic                            debug_exc_req,
  output logic                            debug_interrupt_flag
);
  import pbo_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // programmed state

  logic [DATA_W-1:0] brk_addr_lo;
  logic [HIGH_W-1:0] brk_addr_hi;
  logic [DATA_W-1:0] brk_data;
  logic [DATA_W-1:0] data_mask;
  logic [LAM_W-1:0]  low_addr_mask;
  logic [HIGH_W-1:0] high_addr_mask;
  logic              store_cached_compare_en;
  logic              store_uncached_compare_en;
  logic              overlay_on_alias;
  logic              bus_break_enable;
  logic              break_hit_flag;
  logic              exc_pending;

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  wire sel_status  = (reg_addr == OFF_STATUS);
  wire sel_addr_lo = (reg_addr == OFF_ADDR_LO);
  wire sel_data    = (reg_addr == OFF_DATA);
  wire sel_dmask   = (reg_addr == OFF_DMASK);
  wire sel_ctl     = (reg_addr == OFF_CTL);
  wire sel_addr_hi = (reg_addr == OFF_ADDR_HI);
  wire sel_hmask   = (reg_addr == OFF_HMASK);

  wire wr_go = reg_wr & clk_en;

  wire [1:0] load_fetch_uncached_compare = LF_SETTING;

  wire [DATA_W-1:0] ctl_view = {low_addr_mask, store_cached_compare_en,
                                store_uncached_compare_en,
                                load_fetch_uncached_compare, overlay_on_alias,
                                CTL_RSVD_VAL, bus_break_enable};

  wire [DATA_W-1:0] sts_view = STS_CONST | {31'h0000_0000, break_hit_flag};

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    if (sel_status) begin
      rd_mux = sts_view;
    end else if (sel_addr_lo) begin
      rd_mux = brk_addr_lo;
    end else if (sel_data) begin
      rd_mux = brk_data;
    end else if (sel_dmask) begin
      rd_mux = data_mask;
    end else if (sel_ctl) begin
      rd_mux = ctl_view;
    end else if (sel_addr_hi) begin
      rd_mux = {28'h000_0000, brk_addr_hi};
    end else if (sel_hmask) begin
      rd_mux = {28'h000_0000, high_addr_mask};
    end else begin
      rd_mux = ZERO_W;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address and data comparison

  // low word and high nibble form the break address
  wire [PHYS_W-1:0] brk_addr36 = {brk_addr_hi, brk_addr_lo};

  // overlay widens the mask; break leaves bits 31:24 compared
  wire [7:0] upper_mask = overlay_on_alias ? data_mask[DATA_W-1:UOAM_LSB]
                                           : ZERO_UP;
  wire [PHYS_W-1:0] addr_mask36 = {high_addr_mask, upper_mask, low_addr_mask};

  // data mask applies only without overlay
  wire [DATA_W-1:0] dmask_eff = overlay_on_alias ? ZERO_W : data_mask;

  logic [PHYS_W-1:0] addr_bit_ok;
  logic [DATA_W-1:0] data_bit_ok;

  genvar gi;
  generate
    for (gi = 0; gi < PHYS_W; gi++) begin : g_cmp
      assign addr_bit_ok[gi] = addr_mask36[gi] |
                               (bus_addr[gi] == brk_addr36[gi]);
      if (gi < DATA_W) begin : g_data
        assign data_bit_ok[gi] = dmask_eff[gi] |
                                 (bus_data[gi] == brk_data[gi]);
      end
    end
  endgenerate

  wire addr_match = &addr_bit_ok;
  wire data_match = &data_bit_ok;

  wire class_ok = bus_is_store
                ? (bus_cached ? store_cached_compare_en
                              : store_uncached_compare_en)
                : (~bus_cached & (load_fetch_uncached_compare ==
                                  LF_COMPARE_ON));

  // break hit only with break enabled
  wire brk_hit = clk_en & bus_req_valid & bus_break_enable &
                 ~overlay_on_alias & class_ok & addr_match & data_match;

  // overlay redirect; combinational so the request turns this cycle
  assign overlay_redirect = bus_req_valid & overlay_on_alias & addr_match;

  // exception held back while already in debug mode
  assign debug_exc_req = exc_pending & ~debug_mode_active;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  wire [DATA_W-1:0] next_data_mask = {reg_wdata[DATA_W-1:UOAM_LSB],
                                      data_mask[UOAM_LSB-1:0]};

  // write side, fields start cleared for a known value
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      brk_addr_lo               <= ZERO_W;
      brk_addr_hi               <= ZERO_HIGH;
      brk_data                  <= ZERO_W;
      data_mask                 <= ZERO_W;
      low_addr_mask             <= ZERO_LAM;
      high_addr_mask            <= ZERO_HIGH;
      store_cached_compare_en   <= 1'b0;
      store_uncached_compare_en <= 1'b0;
      overlay_on_alias          <= 1'b0;
      bus_break_enable          <= 1'b0;
    end else if (wr_go) begin
      if (sel_addr_lo) begin
        brk_addr_lo <= reg_wdata;
      end
      if (sel_data) begin
        brk_data <= reg_wdata;
      end
      // only the upper overlay mask takes writes
      if (sel_dmask && overlay_on_alias) begin
        data_mask <= next_data_mask;
      end
      if (sel_ctl) begin
        low_addr_mask             <= reg_wdata[DATA_W-1:CTL_LAM_LSB];
        store_cached_compare_en   <= reg_wdata[CTL_SC_BIT];
        store_uncached_compare_en <= reg_wdata[CTL_SU_BIT];
        overlay_on_alias          <= reg_wdata[CTL_OVL_BIT];
        bus_break_enable          <= reg_wdata[CTL_BE_BIT];
      end
      if (sel_addr_hi) begin
        brk_addr_hi <= reg_wdata[HIGH_W-1:0];
      end
      if (sel_hmask) begin
        high_addr_mask <= reg_wdata[HIGH_W-1:0];
      end
    end
  end

  // status clear on write of zero; a hit in the same cycle wins
  wire sts_clear = wr_go & sel_status & ~reg_wdata[STS_BS_BIT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      break_hit_flag <= 1'b0;
    end else if (brk_hit) begin
      break_hit_flag <= 1'b1;
    end else if (clk_en && (probe_proc_reset || sts_clear)) begin
      break_hit_flag <= 1'b0;
    end
  end

  // imprecise: raised a cycle after the access, no instruction tag
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exc_pending          <= 1'b0;
      debug_interrupt_flag <= 1'b0;
    end else if (clk_en) begin
      debug_interrupt_flag <= brk_hit;
      if (brk_hit) begin
        exc_pending <= 1'b1;
      end else if (debug_exc_ack && !debug_mode_active) begin
        exc_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= ZERO_W;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : ZERO_W;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_hit_sets_flag: assert property (
    @(posedge mclk) disable iff (sys_rst)
    brk_hit |=> break_hit_flag && debug_interrupt_flag && exc_pending)
    else $error("break hit did not set status and interrupt flag");

  a_idle_no_action: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!bus_break_enable && !overlay_on_alias) |-> !overlay_redirect && !brk_hit)
    else $error("action taken with both enables clear");

  a_dm_holds_exc: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (exc_pending && debug_mode_active) |-> !debug_exc_req ##1
    (exc_pending || !clk_en || !$past(clk_en)))
    else $error("pending exception lost or raised in debug mode");

  a_redirect_match: assert property (
    @(posedge mclk) disable iff (sys_rst)
    overlay_redirect |-> overlay_on_alias &&
    (((bus_addr ^ {brk_addr_hi, brk_addr_lo}) &
      ~{high_addr_mask, data_mask[31:24], low_addr_mask}) == 36'h0_0000_0000))
    else $error("redirect without a masked address match");

  a_cached_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_is_store && bus_cached && !store_cached_compare_en) |-> !brk_hit)
    else $error("cached store matched with compare disabled");

  a_uncached_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_is_store && !bus_cached && !store_uncached_compare_en) |-> !brk_hit)
    else $error("uncached store matched with compare disabled");

  a_ctl_reserved: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (clk_en && reg_rd && sel_ctl) |=> reg_rdata[2:1] == 2'h0 &&
    reg_rdata[5:4] == LF_SETTING)
    else $error("control reserved or fixed bits read wrong");

  a_status_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (sts_clear && !brk_hit) |=> !break_hit_flag)
    else $error("break status not cleared by write of zero");

  a_break_upper: assert property (
    @(posedge mclk) disable iff (sys_rst)
    brk_hit |-> bus_addr[31:24] == brk_addr_lo[31:24] &&
    ((bus_data ^ brk_data) & ~data_mask) == 32'h0000_0000)
    else $error("break hit ignored upper address or data mask");

  a_enables_reset: assert property (
    @(posedge mclk)
    sys_rst |=> !bus_break_enable && !overlay_on_alias && !break_hit_flag)
    else $error("enables or status not cleared by reset");

  a_full_match_hits: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (clk_en && bus_req_valid && bus_break_enable && !overlay_on_alias &&
     class_ok && addr_match &&
     (((bus_data ^ brk_data) & ~data_mask) == ZERO_W)) |-> brk_hit)
    else $error("masked address and data match raised no break");

  a_ovl_full_redirect: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (bus_req_valid && overlay_on_alias &&
     (((bus_addr ^ brk_addr36) &
       ~{high_addr_mask, data_mask[DATA_W-1:UOAM_LSB], low_addr_mask}) ==
      36'h0_0000_0000)) |-> overlay_redirect)
    else $error("masked overlay match not redirected");

  a_low_mask_miss: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (((bus_addr[LAM_W-1:0] ^ brk_addr_lo[LAM_W-1:0]) & ~low_addr_mask) !=
     ZERO_LAM) |-> !brk_hit && !overlay_redirect)
    else $error("unmasked low address bit mismatch still matched");

  a_high_mask_miss: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (((bus_addr[PHYS_W-1:DATA_W] ^ brk_addr_hi) & ~high_addr_mask) !=
     ZERO_HIGH) |-> !brk_hit && !overlay_redirect)
    else $error("unmasked high address bit mismatch still matched");

  a_load_cached_off: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!bus_is_store && bus_cached) |-> !brk_hit)
    else $error("cached load or fetch raised a break");

  a_break_off: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !bus_break_enable |-> !brk_hit)
    else $error("break hit with break enable clear");

  a_exc_released: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (exc_pending && !debug_mode_active) |-> debug_exc_req)
    else $error("pending exception not raised outside debug mode");

  a_int_one_cycle: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (clk_en && !brk_hit) |=> !debug_interrupt_flag)
    else $error("debug interrupt flag without a break hit");

  a_flag_holds: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (break_hit_flag && !sts_clear &&
     !(clk_en && probe_proc_reset)) |=> break_hit_flag)
    else $error("break status lost without a clear");

  a_probe_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (clk_en && probe_proc_reset && !brk_hit) |=> !break_hit_flag)
    else $error("break status not cleared by probe reset");

  a_dmask_ro: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (clk_en && reg_wr && sel_dmask && !overlay_on_alias) |=>
    $stable(data_mask))
    else $error("data mask written outside overlay mode");

  a_ack_clears: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (clk_en && debug_exc_ack && !debug_mode_active && !brk_hit) |=>
    !exc_pending)
    else $error("taken exception still pending");

  a_rdata_one_cycle: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (clk_en && !reg_rd) |=> reg_rdata == ZERO_W)
    else $error("read data stands outside its cycle");

endmodule : pbo_bus_break

// *** sim/pbo_core_model.sv ***
`timescale 1ns/1ps
// core side: takes the imprecise debug exception a few cycles late
module pbo_core_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic ack_slow,
  input  wire logic debug_exc_req,
  output logic      debug_exc_ack
);
  logic [1:0] req_seen;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_seen      <= 2'h0;
      debug_exc_ack <= 1'b0;
    end else begin
      req_seen      <= {req_seen[0], debug_exc_req & ~debug_exc_ack};
      // slow path waits one more cycle so both latencies get exercised
      debug_exc_ack <= (ack_slow ? req_seen[1] : req_seen[0])
                       & debug_exc_req & ~debug_exc_ack;
    end
  end
endmodule : pbo_core_model

// *** sim/tb_processor_bus_break_overlay.sv ***
`timescale 1ns/1ps
module tb_processor_bus_break_overlay;
  import pbo_pkg::*;
  logic mclk, sys_rst, reg_wr, reg_rd, valid, st, ca, dm, ack, prst, slow, en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, bdata;
  logic [PHYS_W-1:0] baddr;
  logic              redir, req, flag;
  int                mismatches, n_checks;
  pbo_bus_break u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .bus_req_valid(valid), .bus_addr(baddr),
    .bus_data(bdata), .bus_is_store(st), .bus_cached(ca),
    .debug_mode_active(dm), .debug_exc_ack(ack), .probe_proc_reset(prst),
    .overlay_redirect(redir), .debug_exc_req(req),
    .debug_interrupt_flag(flag));
  pbo_core_model u_core (.mclk(mclk), .sys_rst(sys_rst), .ack_slow(slow),
    .debug_exc_req(req), .debug_exc_ack(ack));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1; addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk_word(rdata, exp);
  endtask : rd
  // one request; redirect seen same cycle, break flag one cycle later
  task automatic bus(input logic [35:0] a, input logic [31:0] d,
                     input logic s, c, exp_redir, exp_flag);
    @(posedge mclk);
    valid <= 1'b1; baddr <= a; bdata <= d; st <= s; ca <= c;
    #1 chk_bit(redir, exp_redir);
    @(posedge mclk);
    valid <= 1'b0;
    #1 chk_bit(flag, exp_flag);
  endtask : bus
  task automatic wait_req_low;
    for (int i = 0; i < 20 && req !== 1'b0; i++) @(posedge mclk);
    #1 chk_bit(req, 1'b0);
  endtask : wait_req_low
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs;
    rd(OFF_CTL, 32'h0000_0030);
    rd(OFF_STATUS, STS_CONST);
    rd(12'h0FC, ZERO_W);
    wr(OFF_CTL, 32'hFFFF_FFC7);
    rd(OFF_CTL, 32'hFFFF_FFF1);
    wr(OFF_DMASK, 32'hFFFF_FFFF);
    rd(OFF_DMASK, ZERO_W);
  endtask : t_reset_regs
  task automatic t_break;
    logic [35:0] m;
    m = 36'h5_1234_5678;
    wr(OFF_ADDR_LO, 32'h1234_5678);
    wr(OFF_ADDR_HI, 32'hFFFF_FFF5);
    wr(OFF_DATA, 32'hCAFE_0000);
    wr(OFF_HMASK, ZERO_W);
    wr(OFF_CTL, 32'h0000_01C1);
    rd(OFF_ADDR_LO, 32'h1234_5678);
    rd(OFF_ADDR_HI, 32'h0000_0005);
    rd(OFF_DATA, 32'hCAFE_0000);
    bus(m, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b1);
    chk_bit(req, 1'b1);
    wait_req_low();
    bus(m, 32'hCAFE_0000, 1'b1, 1'b1, 1'b0, 1'b1);
    bus(m | 36'h1, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b1);
    bus(m ^ 36'h100_0000, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    bus(m, 32'hCAFE_0001, 1'b1, 1'b0, 1'b0, 1'b0);
    bus(m, 32'hCAFE_0000, 1'b0, 1'b0, 1'b0, 1'b1);
    bus(m, 32'hCAFE_0000, 1'b0, 1'b1, 1'b0, 1'b0);
    bus(36'h4_1234_5678, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(OFF_CTL, 32'h0000_0041);
    bus(m, 32'hCAFE_0000, 1'b1, 1'b1, 1'b0, 1'b0);
    wr(OFF_CTL, 32'h0000_0081);
    bus(m, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(OFF_STATUS, STS_CONST | 32'h1);
    wr(OFF_STATUS, ZERO_W);
    rd(OFF_STATUS, STS_CONST);
    wait_req_low();
  endtask : t_break
  task automatic t_debug_mode;
    @(posedge mclk);
    slow <= 1'b1;
    dm <= 1'b1;
    wr(OFF_CTL, 32'h0000_0041);
    bus(36'h5_1234_5678, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge mclk);
    #1 chk_bit(req, 1'b0);
    @(posedge mclk);
    dm <= 1'b0;
    @(posedge mclk);
    #1 chk_bit(req, 1'b1);
    wait_req_low();
    @(posedge mclk);
    prst <= 1'b1;
    @(posedge mclk);
    prst <= 1'b0;
    rd(OFF_STATUS, STS_CONST);
  endtask : t_debug_mode
  task automatic t_overlay;
    wr(OFF_CTL, 32'h0000_0008);
    // upper mask only, low bits left zero
    wr(OFF_DMASK, 32'h4000_0000);
    rd(OFF_DMASK, 32'h4000_0000);
    wr(OFF_HMASK, 32'h0000_0001);
    rd(OFF_HMASK, 32'h0000_0001);
    rd(OFF_CTL, 32'h0000_0038);
    // break stays off, memory addresses only
    bus(36'h5_1234_5678, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    bus(36'h5_5234_5678, 32'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    bus(36'h4_1234_5678, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    bus(36'h7_1234_5678, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    bus(36'h5_1234_5670, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(OFF_CTL, ZERO_W);
    bus(36'h5_1234_5678, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask : t_overlay
  // frozen enable: no hit, no write; then a hit once running again
  task automatic t_clk_en;
    logic [35:0] m;
    m = 36'h5_1234_5678;
    wr(OFF_CTL, 32'h0000_0041);
    @(posedge mclk);
    en <= 1'b0;
    bus(m, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(OFF_CTL, ZERO_W);
    @(posedge mclk);
    en <= 1'b1;
    rd(OFF_STATUS, STS_CONST);
    rd(OFF_CTL, 32'h0000_0071);
    bus(m, 32'hCAFE_0000, 1'b1, 1'b0, 1'b0, 1'b1);
  endtask : t_clk_en
  // hard reset in mid-run clears enables, status and mask
  task automatic t_mid_reset;
    wr(OFF_CTL, 32'h0000_0008);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1 chk_bit(req, 1'b0);
    rd(OFF_CTL, 32'h0000_0030);
    rd(OFF_STATUS, STS_CONST);
    rd(OFF_DMASK, ZERO_W);
  endtask : t_mid_reset
  //////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0; n_checks = 0;
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; addr = 12'h000;
    wdata = 32'h0; valid = 1'b0; baddr = 36'h0; bdata = 32'h0;
    st = 1'b0; ca = 1'b0; dm = 1'b0; prst = 1'b0; slow = 1'b0; en = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset_regs();
    t_break();
    t_debug_mode();
    t_overlay();
    t_clk_en();
    t_mid_reset();
    end_of_test();
  end
  // whole run needs well under 1000 cycles
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_processor_bus_break_overlay
